// File: include/csr_pkg.sv
// Constants for the core special register block
package csr_pkg;
    // Wishbone byte addresses (word per register)
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_STACK = 8'h04;
    localparam logic [7:0] ADDR_DP_LOW = 8'h08;
    localparam logic [7:0] ADDR_DP_HIGH = 8'h0c;
    localparam logic [7:0] ADDR_ACC = 8'h10;
    // Status word bit positions
    localparam int BIT_CARRY = 7;
    localparam int BIT_AUX = 6;
    localparam int BIT_USER0 = 5;
    localparam int BIT_BANK_HI = 4;
    localparam int BIT_BANK_LO = 3;
    localparam int BIT_OVF = 2;
    localparam int BIT_USER1 = 1;
    localparam int BIT_PARITY = 0;
    // Reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] STACK_RST = 8'h07;
    localparam logic [7:0] DP_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] ACC_RST = 8'h00;
    // Bank base is bank number shifted left by this many bits
    localparam int BANK_SHIFT = 3;
    // Address source selects for external accesses
    typedef enum logic [1:0] {
        CSR_SRC_NONE,
        CSR_SRC_CODE_IDX,
        CSR_SRC_CODE,
        CSR_SRC_DATA
    } csr_src_e;
endpackage

// File: hw/csr_core_regs.sv
// Core special registers: status word, stack, data pointer, program counter
`timescale 1ns/1ps

// What this block does
// - Bank bits 4,3 pick register bank base
// - Parity bit tracks accumulator even parity
// - User flags bits 5,1 software only
// - Stack pointer eight bits, resets 0x07
// - Stack pointer increments before push, call
// - Data pointer low, high bytes addressable
// - Data pointer written whole or bytewise
// - Data pointer addresses external code, data
// - Program counter sixteen bits, resets zero
// - Counter advances on opcode, operand fetch
// - Program counter has no register address
// - Status word resets to all zeros
module csr_core_regs (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // Wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    output logic O_WB_ERR,
    // Execution unit: accumulator and flags
    input wire logic I_ACC_WE,
    input wire logic [7:0] I_ACC_DAT,
    input wire logic I_ALU_FLAGS_WE,
    input wire logic I_CARRY,
    input wire logic I_AUX_CARRY,
    input wire logic I_OVERFLOW,
    // Execution unit: stack
    input wire logic I_PUSH,
    input wire logic I_POP,
    // Execution unit: data pointer
    input wire logic I_DP_LOAD16,
    input wire logic [15:0] I_DP_DAT16,
    input wire logic I_DP_INC,
    // Execution unit: program counter
    input wire logic I_FETCH,
    input wire logic I_PC_LOAD,
    input wire logic [15:0] I_PC_DAT,
    // External address request
    input wire logic [1:0] I_EXT_SRC,
    // Outputs
    output logic [7:0] O_STATUS,
    output logic [7:0] O_ACC,
    output logic [7:0] O_STACK_PTR,
    output logic [7:0] O_PUSH_ADDR,
    output logic [15:0] O_DATA_PTR,
    output logic [15:0] O_PROG_CNT,
    output logic [7:0] O_BANK_BASE,
    output logic [15:0] O_EXT_ADDR,
    output logic O_EXT_CODE,
    output logic O_EXT_VALID
);

    // ==========================================
    // Bus decode
    // ==========================================
    logic req;
    logic wr;
    logic hit_status;
    logic hit_stack;
    logic hit_dpl;
    logic hit_dph;
    logic hit_acc;
    logic mapped;
    logic ack_r;
    logic err_r;
    logic [31:0] rdat_r;
    logic [31:0] rdat_nxt;

    // One-cycle pause after each ack or err keeps a held request from being answered in back-to-back cycles
    assign req = I_WB_CYC && I_WB_STB && !ack_r && !err_r;
    assign hit_status = (I_WB_ADR == csr_pkg::ADDR_STATUS);
    assign hit_stack = (I_WB_ADR == csr_pkg::ADDR_STACK);
    assign hit_dpl = (I_WB_ADR == csr_pkg::ADDR_DP_LOW);
    assign hit_dph = (I_WB_ADR == csr_pkg::ADDR_DP_HIGH);
    assign hit_acc = (I_WB_ADR == csr_pkg::ADDR_ACC);
    // No address reaches the program counter
    assign mapped = hit_status || hit_stack || hit_dpl || hit_dph || hit_acc;
    assign wr = req && mapped && I_WB_WE && I_WB_SEL[0];

    // ==========================================
    // Registers
    // ==========================================
    logic [7:0] status_flags_word_r;
    logic [7:0] stack_top_pointer_r;
    logic [7:0] data_pointer_low_byte_r;
    logic [7:0] data_pointer_high_byte_r;
    logic [15:0] program_counter_r;
    logic [7:0] acc_r;
    logic [7:0] acc_nxt;
    logic parity_nxt;
    logic [7:0] status_flags_word_nxt;
    logic [7:0] stack_top_pointer_nxt;
    logic [7:0] push_addr_r;
    logic [1:0] bank_nxt;
    logic [7:0] bank_base_r;

    // Bank bits as they stand after reset
    localparam logic [1:0] BANK_RST = {csr_pkg::STATUS_RST[csr_pkg::BIT_BANK_HI],
                                       csr_pkg::STATUS_RST[csr_pkg::BIT_BANK_LO]};

    // Core write wins: the bus cannot race an instruction
    assign acc_nxt = I_ACC_WE ? I_ACC_DAT : ((wr && hit_acc) ? I_WB_DAT[7:0] : acc_r);
    assign parity_nxt = ^acc_nxt;

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            acc_r <= csr_pkg::ACC_RST;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // Bus write first, then hardware flags on top of it in the same cycle
    always_comb begin
        status_flags_word_nxt = status_flags_word_r;
        if (wr && hit_status) begin
            // User flags and bank bits only change here
            status_flags_word_nxt = I_WB_DAT[7:0];
        end
        if (I_ALU_FLAGS_WE) begin
            status_flags_word_nxt[csr_pkg::BIT_CARRY] = I_CARRY;
            status_flags_word_nxt[csr_pkg::BIT_AUX] = I_AUX_CARRY;
            status_flags_word_nxt[csr_pkg::BIT_OVF] = I_OVERFLOW;
        end
        // Parity is read-only: a write cannot disturb it
        status_flags_word_nxt[csr_pkg::BIT_PARITY] = parity_nxt;
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            status_flags_word_r <= csr_pkg::STATUS_RST;
        end else begin
            status_flags_word_r <= status_flags_word_nxt;
        end
    end

    assign bank_nxt = {status_flags_word_nxt[csr_pkg::BIT_BANK_HI],
                       status_flags_word_nxt[csr_pkg::BIT_BANK_LO]};

    // Base kept in a flop of its own so the output follows the status word exactly
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            bank_base_r <= 8'(BANK_RST) << csr_pkg::BANK_SHIFT;
        end else begin
            bank_base_r <= 8'(bank_nxt) << csr_pkg::BANK_SHIFT;
        end
    end

    // Push wins over pop, and both over a bus write in the same cycle
    always_comb begin
        stack_top_pointer_nxt = stack_top_pointer_r;
        if (I_PUSH) begin
            stack_top_pointer_nxt = stack_top_pointer_r + 8'h01;
        end else if (I_POP) begin
            stack_top_pointer_nxt = stack_top_pointer_r - 8'h01;
        end else if (wr && hit_stack) begin
            stack_top_pointer_nxt = I_WB_DAT[7:0];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            stack_top_pointer_r <= csr_pkg::STACK_RST;
        end else begin
            stack_top_pointer_r <= stack_top_pointer_nxt;
        end
    end

    // Next push target registered, so the core can store before the pointer moves
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            push_addr_r <= csr_pkg::STACK_RST + 8'h01;
        end else begin
            push_addr_r <= stack_top_pointer_nxt + 8'h01;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            data_pointer_low_byte_r <= csr_pkg::DP_RST;
            data_pointer_high_byte_r <= csr_pkg::DP_RST;
        // Core strobes win over bus writes landing in the same cycle
        end else if (I_DP_LOAD16) begin
            data_pointer_high_byte_r <= I_DP_DAT16[15:8];
            data_pointer_low_byte_r <= I_DP_DAT16[7:0];
        end else if (I_DP_INC) begin
            {data_pointer_high_byte_r, data_pointer_low_byte_r} <=
                {data_pointer_high_byte_r, data_pointer_low_byte_r} + 16'h0001;
        end else begin
            if (wr && hit_dpl) begin
                data_pointer_low_byte_r <= I_WB_DAT[7:0];
            end
            if (wr && hit_dph) begin
                data_pointer_high_byte_r <= I_WB_DAT[7:0];
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            program_counter_r <= csr_pkg::PC_RST;
        // A jump replaces the count outright, even during a fetch
        end else if (I_PC_LOAD) begin
            program_counter_r <= I_PC_DAT;
        end else if (I_FETCH) begin
            program_counter_r <= program_counter_r + 16'h0001;
        end
    end

    // ==========================================
    // Bus answer
    // ==========================================
    always_comb begin
        rdat_nxt = 32'h0000_0000;
        if (hit_status) begin
            rdat_nxt[7:0] = status_flags_word_r;
        end else if (hit_stack) begin
            rdat_nxt[7:0] = stack_top_pointer_r;
        end else if (hit_dpl) begin
            rdat_nxt[7:0] = data_pointer_low_byte_r;
        end else if (hit_dph) begin
            rdat_nxt[7:0] = data_pointer_high_byte_r;
        end else if (hit_acc) begin
            rdat_nxt[7:0] = acc_r;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r <= req && mapped;
            err_r <= req && !mapped;
            if (req) begin
                rdat_r <= rdat_nxt;
            end
        end
    end

    // ==========================================
    // Outputs
    // ==========================================
    logic [15:0] data_pointer_word;
    logic [15:0] ext_addr_r;
    logic ext_code_r;
    logic ext_valid_r;

    assign data_pointer_word = {data_pointer_high_byte_r, data_pointer_low_byte_r};

    // Address is held while idle so a slow memory can keep using it
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            ext_addr_r <= {csr_pkg::DP_RST, csr_pkg::DP_RST};
        end else begin
            case (csr_pkg::csr_src_e'(I_EXT_SRC))
                csr_pkg::CSR_SRC_CODE_IDX: ext_addr_r <= data_pointer_word + {8'h00, acc_r};
                csr_pkg::CSR_SRC_CODE: ext_addr_r <= data_pointer_word;
                csr_pkg::CSR_SRC_DATA: ext_addr_r <= data_pointer_word;
                default: ext_addr_r <= ext_addr_r;
            endcase
        end
    end

    // Kind of access travels with the address, one cycle after the request
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            ext_code_r <= 1'b0;
            ext_valid_r <= 1'b0;
        end else begin
            ext_valid_r <= (I_EXT_SRC != 2'(csr_pkg::CSR_SRC_NONE));
            ext_code_r <= (I_EXT_SRC != 2'(csr_pkg::CSR_SRC_DATA));
        end
    end

    assign O_WB_ACK = ack_r;
    assign O_WB_ERR = err_r;
    assign O_WB_DAT = rdat_r;
    assign O_STATUS = status_flags_word_r;
    assign O_ACC = acc_r;
    assign O_STACK_PTR = stack_top_pointer_r;
    assign O_PUSH_ADDR = push_addr_r;
    assign O_DATA_PTR = data_pointer_word;
    assign O_PROG_CNT = program_counter_r;
    assign O_BANK_BASE = bank_base_r;
    assign O_EXT_ADDR = ext_addr_r;
    assign O_EXT_CODE = ext_code_r;
    assign O_EXT_VALID = ext_valid_r;

endmodule // csr_core_regs

// File: dv/csr_core_regs_assertions.sv
// Port checks for the core special registers
`timescale 1ns/1ps
module csr_core_regs_chk (
    // Clock, reset, bus
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic O_WB_ACK,
    input wire logic O_WB_ERR,
    // Core strobes
    input wire logic I_PUSH,
    input wire logic I_FETCH,
    input wire logic I_PC_LOAD,
    input wire logic [1:0] I_EXT_SRC,
    // Registers
    input wire logic [7:0] O_STATUS,
    input wire logic [7:0] O_ACC,
    input wire logic [7:0] O_STACK_PTR,
    input wire logic [7:0] O_PUSH_ADDR,
    input wire logic [15:0] O_DATA_PTR,
    input wire logic [15:0] O_PROG_CNT,
    input wire logic [7:0] O_BANK_BASE,
    input wire logic [15:0] O_EXT_ADDR,
    input wire logic O_EXT_CODE,
    input wire logic O_EXT_VALID
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    // ====
    // Bus steps
    sequence bus_req;
        $rose(I_WB_CYC && I_WB_STB);
    endsequence
    sequence bus_answer;
        (O_WB_ACK != O_WB_ERR) ##1 (!O_WB_ACK && !O_WB_ERR);
    endsequence
    bus_ack_a: assert property (bus_req |=> bus_answer)
        else $error("bus answer not one cycle");
    unmapped_err_a: assert property (bus_req ##0
        !(I_WB_ADR inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}) |=> O_WB_ERR && !O_WB_ACK)
        else $error("unmapped access not refused");
    bank_base_a: assert property (O_BANK_BASE == {3'h0, O_STATUS[4:3], 3'h0})
        else $error("bank base wrong");
    parity_even_a: assert property (O_STATUS[0] == ^O_ACC)
        else $error("parity flag wrong");
    user_flags_a: assert property (!(I_WB_CYC && I_WB_STB && I_WB_WE)
        |=> $stable({O_STATUS[5], O_STATUS[1]}))
        else $error("user flag changed by hardware");
    reset_values_a: assert property ($fell(I_RESET) |->
        O_STATUS == 8'h00 && O_STACK_PTR == 8'h07 && O_PROG_CNT == 16'h0000)
        else $error("reset value wrong");
    push_addr_a: assert property (I_PUSH |=> O_STACK_PTR == $past(O_PUSH_ADDR))
        else $error("stack not pre-incremented");
    pc_fetch_a: assert property (I_FETCH && !I_PC_LOAD
        |=> O_PROG_CNT == $past(O_PROG_CNT) + 16'h0001)
        else $error("counter did not advance");
    ext_code_a: assert property (I_EXT_SRC == 2'h1 |=> O_EXT_VALID && O_EXT_CODE &&
        O_EXT_ADDR == $past(O_DATA_PTR) + {8'h00, $past(O_ACC)})
        else $error("indexed code address wrong");
endmodule // csr_core_regs_chk

// File: dv/csr_core_regs_test.sv
// Self-checking bench for the core special registers
`timescale 1ns/1ps
module csr_core_regs_test;
    // Port names kept so the instance connects by name
    logic I_CLK = 1'h0, I_RESET = 1'h1, I_WB_CYC = 1'h0, I_WB_STB = 1'h0, I_WB_WE = 1'h0;
    logic I_ACC_WE = 1'h0, I_ALU_FLAGS_WE = 1'h0, I_CARRY = 1'h0, I_AUX_CARRY = 1'h0;
    logic I_OVERFLOW = 1'h0, I_PUSH = 1'h0, I_POP = 1'h0, I_DP_LOAD16 = 1'h0, I_DP_INC = 1'h0;
    logic I_FETCH = 1'h0, I_PC_LOAD = 1'h0, O_WB_ACK, O_WB_ERR, O_EXT_CODE, O_EXT_VALID, er;
    logic [7:0] I_WB_ADR = 8'h00, I_ACC_DAT = 8'h00, O_STATUS, O_ACC, O_STACK_PTR;
    logic [7:0] O_PUSH_ADDR, O_BANK_BASE;
    logic [3:0] I_WB_SEL = 4'h0;
    logic [31:0] I_WB_DAT = 32'h0, O_WB_DAT, rd;
    logic [15:0] I_DP_DAT16 = 16'h0, I_PC_DAT = 16'h0, O_DATA_PTR, O_PROG_CNT, O_EXT_ADDR;
    logic [1:0] I_EXT_SRC = 2'h0;
    int num_errors = 0;
    int checked = 0;
    csr_core_regs dut (.*);
    always #10 I_CLK = ~I_CLK;
    // ====
    // Shared tasks
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge I_CLK);
        {I_WB_CYC, I_WB_STB, I_WB_WE, I_WB_ADR, I_WB_SEL} <= {2'h3, w, a, 4'hf};
        I_WB_DAT <= {24'h0, d};
        n = 0;
        // Waits as long as it takes; only the watchdog ends a hang
        do begin
            @(posedge I_CLK);
            n++;
        end while (O_WB_ACK !== 1'h1 && O_WB_ERR !== 1'h1);
        rd = O_WB_DAT;
        er = O_WB_ERR;
        {I_WB_CYC, I_WB_STB, I_WB_WE} <= 3'h0;
        #1 chk("bus answer cycles", 16'h0002, 16'(n));
    endtask
    task automatic test_done;
        $display("Errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ====
    // Scenarios
    task automatic t_reset;
        wb(1'h0, csr_pkg::ADDR_STACK, 8'h00);
        chk("stack", 16'h0007, rd[15:0]);
        chk("status", 16'h0000, {8'h0, O_STATUS});
        chk("pc", 16'h0000, O_PROG_CNT);
        $display("reset test done");
    endtask
    task automatic t_bank;
        for (int b = 0; b < 4; b++) begin
            wb(1'h1, csr_pkg::ADDR_STATUS, 8'h22 | 8'(b * 8));
            chk("bank base", 16'(b * 8), {8'h0, O_BANK_BASE});
        end
        @(posedge I_CLK) {I_CARRY, I_AUX_CARRY, I_OVERFLOW, I_ALU_FLAGS_WE} <= 4'hf;
        @(posedge I_CLK) I_ALU_FLAGS_WE <= 1'h0;
        #1 chk("alu flags", 16'h00fe, {8'h0, O_STATUS});
        $display("bank test done");
    endtask
    task automatic t_parity;
        logic [7:0] v[4] = '{8'h01, 8'h03, 8'h80, 8'hff};
        foreach (v[i]) begin
            @(posedge I_CLK) {I_ACC_WE, I_ACC_DAT} <= {1'h1, v[i]};
            @(posedge I_CLK) I_ACC_WE <= 1'h0;
            #1 chk("parity", 16'($countones(v[i]) & 1), {15'h0, O_STATUS[0]});
        end
        wb(1'h1, csr_pkg::ADDR_ACC, 8'h07);
        wb(1'h1, csr_pkg::ADDR_STATUS, 8'h00);
        chk("parity kept", 16'h0001, {15'h0, O_STATUS[0]});
        $display("parity test done");
    endtask
    task automatic t_stack;
        chk("first push", 16'h0008, {8'h0, O_PUSH_ADDR});
        @(posedge I_CLK) I_PUSH <= 1'h1;
        repeat (2) @(posedge I_CLK);
        {I_PUSH, I_POP} <= 2'h1;
        @(posedge I_CLK) I_POP <= 1'h0;
        #1 chk("stack", 16'h0008, {8'h0, O_STACK_PTR});
        $display("stack test done");
    endtask
    task automatic t_data_pointer_word;
        @(posedge I_CLK) {I_DP_LOAD16, I_DP_DAT16} <= {1'h1, 16'h12f0};
        @(posedge I_CLK) I_DP_LOAD16 <= 1'h0;
        #1 chk("data_pointer_word", 16'h12f0, O_DATA_PTR);
        wb(1'h1, csr_pkg::ADDR_DP_LOW, 8'h34);
        wb(1'h1, csr_pkg::ADDR_DP_HIGH, 8'hab);
        wb(1'h0, csr_pkg::ADDR_DP_HIGH, 8'h00);
        chk("data_pointer_word bytes", 16'hab34, {rd[7:0], O_DATA_PTR[7:0]});
        @(posedge I_CLK) I_EXT_SRC <= 2'h1;
        @(posedge I_CLK) I_EXT_SRC <= 2'h3;
        #1 chk("code addr", 16'hab3b, O_EXT_ADDR);
        @(posedge I_CLK) I_EXT_SRC <= 2'h2;
        #1 chk("data addr", 16'hab34, O_EXT_ADDR);
        chk("data kind", 16'h0001, {14'h0, O_EXT_CODE, O_EXT_VALID});
        @(posedge I_CLK) I_EXT_SRC <= 2'h0;
        #1 chk("code kind", 16'h0003, {14'h0, O_EXT_CODE, O_EXT_VALID});
        @(posedge I_CLK);
        #1 chk("idle valid", 16'h0000, {15'h0, O_EXT_VALID});
        chk("idle addr", 16'hab34, O_EXT_ADDR);
        $display("data_pointer_word test done");
    endtask
    task automatic t_pc;
        @(posedge I_CLK) I_FETCH <= 1'h1;
        repeat (3) @(posedge I_CLK);
        {I_FETCH, I_PC_LOAD, I_PC_DAT} <= {2'h1, 16'hffff};
        @(posedge I_CLK) {I_FETCH, I_PC_LOAD} <= 2'h2;
        @(posedge I_CLK) I_FETCH <= 1'h0;
        #1 chk("pc wrap", 16'h0000, O_PROG_CNT);
        wb(1'h0, 8'h14, 8'h00);
        chk("pc unmapped", 16'h0001, {15'h0, er});
        $display("pc test done");
    endtask
    initial begin
        repeat (4) @(posedge I_CLK);
        I_RESET <= 1'h0;
        t_reset;
        t_bank;
        t_parity;
        t_stack;
        t_data_pointer_word;
        t_pc;
        test_done;
    end
    initial begin
        repeat (3000) @(posedge I_CLK);
        num_errors++;
        test_done;
    end
endmodule // csr_core_regs_test
bind csr_core_regs csr_core_regs_chk chk_i (.*);
